/* File: logic/xbus_irq_regs.svh */
// Notes on behaviour
// - Four 16-bit source-select registers, one per vector.
// - High byte holds per-source enable bits.
// - Low byte holds per-source request flags.
// - Enable byte masks sources onto the vector.
// - Flags set even when enable is clear.
// - Vectors serve interrupts and event transfers alike.
// - Serial receive/transmit routable to vectors 0-2.
// - Vector 3 collects errors, clock; CAN/PWM fixed.
// - Class A traps rank second, own numbers.
// - Class B traps share vector 0028h, own flags.
// - Class B traps share lowest hardware priority.
// - Hardware trap service forces level fifteen.
// - Each class A and class B trap sets its flag bit; reset has none.
// - Trap service preempted only by higher trap.
`ifndef XBUS_IRQ_REGS_SVH
`define XBUS_IRQ_REGS_SVH
`define SEL0_ADDR      8'h00
`define SEL1_ADDR      8'h04
`define SEL2_ADDR      8'h08
`define SEL3_ADDR      8'h0C
`define TRAP_FLAG_ADDR 8'h10
`define TRAP_STAT_ADDR 8'h14
`define SEL_RESET      16'h0000
`define EN_HI          15
`define EN_LO          8
`define FLG_HI         7
`define FLG_LO         0
`define TF_NMI         15
`define TF_OVERFLOW    14
`define TF_UNDERFLOW   13
`define TF_BAD_OPCODE  7
`define TF_MAC_BREAK   6
`define TF_PROTECT     3
`define TF_BAD_OPERAND 2
`define TF_BAD_FETCH   1
`define TF_BAD_EXT_BUS 0
`define TRAP_FLAG_MASK 16'hE0CF
`define VEC_RESET      9'h000
`define VEC_NMI        9'h008
`define VEC_OVERFLOW   9'h010
`define VEC_UNDERFLOW  9'h018
`define VEC_CLASS_B    9'h028
`define NUM_RESET      7'h00
`define NUM_NMI        7'h02
`define NUM_OVERFLOW   7'h04
`define NUM_UNDERFLOW  7'h06
`define NUM_CLASS_B    7'h0A
`define LEVEL_TOP      4'hF
`define BRESP_OKAY     2'h0
`define BRESP_DECERR   2'h3
`endif

/* File: logic/xbus_irq_pkg.sv */
package xbus_irq_pkg;
   typedef enum logic [2:0]
   {
      PRI_NONE  = 3'b000,
      PRI_SOFT  = 3'b001,
      PRI_B     = 3'b010,
      PRI_A     = 3'b011,
      PRI_RESET = 3'b100
   } trap_pri_t;
   typedef struct packed
   {
      logic [8:0] location;
      logic [6:0] number;
   } trap_vec_t;
endpackage

/* File: logic/xbus_sel_reg.sv */
`timescale 1ns/1ps
`include "xbus_irq_regs.svh"
// One source-select register: enables above, sticky flags below.
module xbus_sel_reg
   import xbus_irq_pkg::*;
#(
   parameter logic [7:0] ROUTE = 8'hFF
)
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] events,
   input  wire logic       wr,
   input  wire logic [3:0] wstrb,
   input  wire logic [15:0] wdata,
   output logic      [15:0] sel,
   output logic            req
);
   logic [7:0] en;
   logic [7:0] flg;
   logic [7:0] ev;
   assign ev  = events & ROUTE;
   assign sel = {en, flg};
   always_ff @(posedge clk)
   begin
      if (!nrst)
         en <= 8'(`SEL_RESET >> `EN_LO);
      else if (wr && wstrb[1])
         en <= wdata[`EN_HI:`EN_LO] & ROUTE;
   end
   // A written one clears a flag; a simultaneous event keeps it set.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         flg <= 8'(`SEL_RESET);
      else if (wr && wstrb[0])
         flg <= (flg & ~wdata[`FLG_HI:`FLG_LO]) | ev;
      else
         flg <= flg | ev;
   end
   always_ff @(posedge clk)
   begin
      if (!nrst)
         req <= 1'b0;
      else
         req <= |(next_and(en, flg));
   end
   function automatic logic [7:0] next_and(input logic [7:0] a, input logic [7:0] b);
      next_and = a & b;
   endfunction
   a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
      ($past(flg) != 8'h00 && !$past(wr && wstrb[0])) |-> ((flg & $past(flg)) == $past(flg)))
      else $error("flag lost without clear");
   a_event_sets: assert property (@(posedge clk) disable iff (!nrst)
      |ev |=> ((flg & $past(ev)) == $past(ev)))
      else $error("event did not set flag");
   a_req_and: assert property (@(posedge clk) disable iff (!nrst)
      ##1 (req == |($past(en) & $past(flg))))
      else $error("vector request mismatch");
endmodule

/* File: logic/xbus_irq_mux.sv */
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "xbus_irq_regs.svh"
// Source order in bytes 0-2: bit0 CAN1 (vector 0 only), 1 CAN2 (vector 1 only), 2 I2C rx, 3 I2C tx, 4 SSC2 rx,
// 5 SSC2 tx, 6 ASC2 rx, 7 ASC2 tx. Vector 3 byte: 0 CAN1, 1 CAN2, 2 I2C err,
// 3 SSC2 err, 4 ASC2 err, 5 clock fault, 6 PWM2, 7 ASC2 tx buffer unused.
// ASC2 tx buffer shares bit 7 with ASC2 tx on vectors 0-2; bit 1 there is PWM2 on 2.
module xbus_irq_mux
   import xbus_irq_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   input  wire logic        CAN1_EV,
   input  wire logic        CAN2_EV,
   input  wire logic        I2C_RX_EV,
   input  wire logic        I2C_TX_EV,
   input  wire logic        I2C_ERR_EV,
   input  wire logic        SSC2_RX_EV,
   input  wire logic        SSC2_TX_EV,
   input  wire logic        SSC2_ERR_EV,
   input  wire logic        ASC2_RX_EV,
   input  wire logic        ASC2_TX_EV,
   input  wire logic        ASC2_TXBUF_EV,
   input  wire logic        ASC2_ERR_EV,
   input  wire logic        CLOCK_FAULT_EV,
   input  wire logic        PWM2_EV,
   input  wire logic        HW_RESET_REQ,
   input  wire logic        SW_RESET_REQ,
   input  wire logic        WDT_RESET_REQ,
   input  wire logic        NMI_REQ,
   input  wire logic        STK_OVER_REQ,
   input  wire logic        STK_UNDER_REQ,
   input  wire logic [5:0]  CLASS_B_REQ,
   input  wire logic        SW_TRAP_REQ,
   input  wire logic [6:0]  SW_TRAP_NUM,
   input  wire logic        TRAP_DONE,
   input  wire logic [3:0]  CPU_LEVEL_IN,
   input  wire logic [31:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [31:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   output logic [3:0]       SHARED_VECTOR,
   output logic             TRAP_TAKE,
   output trap_vec_t        TRAP_VECTOR,
   output logic [3:0]       CPU_INTERRUPT_LEVEL,
   output logic             TRAP_ACTIVE
);
   logic [7:0]  ev [4];
   logic [15:0] sel [4];
   logic [3:0]  req;
   logic [3:0]  sel_wr;
   logic [15:0] trap_flag_register;
   logic [15:0] trap_ev;
   trap_pri_t   cur_pri;
   trap_pri_t   next_pri;
   trap_vec_t   next_vec;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic        ar_hit;

   assign ev[0] = {ASC2_TX_EV | ASC2_TXBUF_EV, ASC2_RX_EV, SSC2_TX_EV, SSC2_RX_EV,
                   I2C_TX_EV, I2C_RX_EV, 1'b0, CAN1_EV};
   assign ev[1] = {ASC2_TX_EV | ASC2_TXBUF_EV, ASC2_RX_EV, SSC2_TX_EV, SSC2_RX_EV,
                   I2C_TX_EV, I2C_RX_EV, CAN2_EV, 1'b0};
   assign ev[2] = {ASC2_TX_EV | ASC2_TXBUF_EV, ASC2_RX_EV, SSC2_TX_EV, SSC2_RX_EV,
                   I2C_TX_EV, I2C_RX_EV, PWM2_EV, 1'b0};
   assign ev[3] = {1'b0, PWM2_EV, CLOCK_FAULT_EV, ASC2_ERR_EV, SSC2_ERR_EV,
                   I2C_ERR_EV, CAN2_EV, CAN1_EV};

   assign do_write = aw_held && w_held && !BVALID;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_sel
         assign sel_wr[g] = do_write && (aw_addr == 8'(g * 4));
         xbus_sel_reg #(.ROUTE(g == 3 ? 8'h7F : (g == 0 ? 8'hFD : 8'hFE))) u_sel
         (
            .clk    (REF_CLK),
            .nrst   (NRST),
            .events (ev[g]),
            .wr     (sel_wr[g]),
            .wstrb  (w_strb),
            .wdata  (w_data[15:0]),
            .sel    (sel[g]),
            .req    (req[g])
         );
      end
   endgenerate

   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         SHARED_VECTOR <= 4'h0;
      else
         SHARED_VECTOR <= req;
   end

   // AXI write: address and data taken in either order, response after both.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= `BRESP_OKAY;
      end
      else
      begin
         AWREADY <= !aw_held && !AWREADY && AWVALID;
         WREADY  <= !w_held && !WREADY && WVALID;
         if (AWVALID && AWREADY)
         begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR[7:0];
         end
         if (WVALID && WREADY)
         begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_write)
         begin
            BVALID  <= 1'b1;
            BRESP   <= (aw_addr < `TRAP_FLAG_ADDR || aw_addr == `TRAP_FLAG_ADDR
                        || aw_addr == `TRAP_STAT_ADDR) && aw_addr[1:0] == 2'h0
                       ? `BRESP_OKAY : `BRESP_DECERR;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
         else if (BVALID && BREADY)
            BVALID <= 1'b0;
      end
   end

   // AXI read.
   assign ar_hit = ARVALID && ARREADY;
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= `BRESP_OKAY;
      end
      else
      begin
         ARREADY <= !ARREADY && !RVALID && ARVALID;
         if (ar_hit)
         begin
            RVALID <= 1'b1;
            RRESP  <= `BRESP_OKAY;
            case (ARADDR[7:0])
               `SEL0_ADDR:      RDATA <= {16'h0000, sel[0]};
               `SEL1_ADDR:      RDATA <= {16'h0000, sel[1]};
               `SEL2_ADDR:      RDATA <= {16'h0000, sel[2]};
               `SEL3_ADDR:      RDATA <= {16'h0000, sel[3]};
               `TRAP_FLAG_ADDR: RDATA <= {16'h0000, trap_flag_register};
               `TRAP_STAT_ADDR: RDATA <= {24'h000000, TRAP_ACTIVE, cur_pri, CPU_INTERRUPT_LEVEL};
               default:
               begin
                  RDATA <= 32'h0000_0000;
                  RRESP <= `BRESP_DECERR;
               end
            endcase
         end
         else if (RVALID && RREADY)
            RVALID <= 1'b0;
      end
   end

   // Hardware trap flags: a written one clears, a new trap wins.
   always_comb
   begin
      trap_ev = 16'h0000;
      trap_ev[`TF_NMI]    = NMI_REQ;
      trap_ev[`TF_OVERFLOW]    = STK_OVER_REQ;
      trap_ev[`TF_UNDERFLOW]   = STK_UNDER_REQ;
      trap_ev[`TF_BAD_OPCODE]  = CLASS_B_REQ[5];
      trap_ev[`TF_MAC_BREAK]   = CLASS_B_REQ[4];
      trap_ev[`TF_PROTECT]     = CLASS_B_REQ[3];
      trap_ev[`TF_BAD_OPERAND] = CLASS_B_REQ[2];
      trap_ev[`TF_BAD_FETCH]   = CLASS_B_REQ[1];
      trap_ev[`TF_BAD_EXT_BUS] = CLASS_B_REQ[0];
   end
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         trap_flag_register <= 16'h0000;
      else if (do_write && aw_addr == `TRAP_FLAG_ADDR)
         trap_flag_register <= (trap_flag_register & ~(w_data[15:0] & {{8{w_strb[1]}},
                                {8{w_strb[0]}}})) | trap_ev;
      else
         trap_flag_register <= trap_flag_register | trap_ev;
   end

   // Priority pick: reset, class A by number, class B, then software trap.
   always_comb
   begin
      next_pri = PRI_NONE;
      next_vec = '{location: `VEC_RESET, number: `NUM_RESET};
      if (HW_RESET_REQ || SW_RESET_REQ || WDT_RESET_REQ)
         next_pri = PRI_RESET;
      else if (NMI_REQ)
      begin
         next_pri = PRI_A;
         next_vec = '{location: `VEC_NMI, number: `NUM_NMI};
      end
      else if (STK_OVER_REQ)
      begin
         next_pri = PRI_A;
         next_vec = '{location: `VEC_OVERFLOW, number: `NUM_OVERFLOW};
      end
      else if (STK_UNDER_REQ)
      begin
         next_pri = PRI_A;
         next_vec = '{location: `VEC_UNDERFLOW, number: `NUM_UNDERFLOW};
      end
      else if (|CLASS_B_REQ)
      begin
         next_pri = PRI_B;
         next_vec = '{location: `VEC_CLASS_B, number: `NUM_CLASS_B};
      end
      else if (SW_TRAP_REQ)
      begin
         next_pri = PRI_SOFT;
         next_vec = '{location: {SW_TRAP_NUM, 2'b00}, number: SW_TRAP_NUM};
      end
   end

   // Service state: only a strictly higher trap may preempt.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         cur_pri             <= PRI_NONE;
         TRAP_TAKE           <= 1'b0;
         TRAP_VECTOR         <= '{location: `VEC_RESET, number: `NUM_RESET};
         TRAP_ACTIVE         <= 1'b0;
         CPU_INTERRUPT_LEVEL <= 4'h0;
      end
      else
      begin
         TRAP_TAKE <= 1'b0;
         if (next_pri != PRI_NONE && (next_pri > cur_pri || (next_pri == PRI_SOFT
             && cur_pri == PRI_NONE)))
         begin
            TRAP_TAKE   <= 1'b1;
            TRAP_VECTOR <= next_vec;
            if (next_pri == PRI_SOFT)
            begin
               CPU_INTERRUPT_LEVEL <= CPU_LEVEL_IN;
            end
            else
            begin
               cur_pri             <= next_pri;
               TRAP_ACTIVE         <= 1'b1;
               CPU_INTERRUPT_LEVEL <= `LEVEL_TOP;
            end
         end
         else if (TRAP_DONE)
         begin
            cur_pri             <= PRI_NONE;
            TRAP_ACTIVE         <= 1'b0;
            CPU_INTERRUPT_LEVEL <= CPU_LEVEL_IN;
         end
         else if (cur_pri == PRI_NONE)
            CPU_INTERRUPT_LEVEL <= CPU_LEVEL_IN;
      end
   end

   a_reset_vec: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (HW_RESET_REQ && cur_pri != PRI_RESET) |=> (TRAP_TAKE && TRAP_VECTOR.location == 9'h000
      && TRAP_VECTOR.number == 7'h00))
      else $error("reset did not vector to zero");
   a_nmi_vec: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (NMI_REQ && !HW_RESET_REQ && !SW_RESET_REQ && !WDT_RESET_REQ && cur_pri < PRI_A)
      |=> (TRAP_TAKE && TRAP_VECTOR.location == 9'h008 && TRAP_VECTOR.number == 7'h02))
      else $error("nmi vector wrong");
   a_class_b_vec: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (TRAP_TAKE && $past(next_pri) == PRI_B) |-> (TRAP_VECTOR.location == 9'h028
      && TRAP_VECTOR.number == 7'h0A))
      else $error("class b vector wrong");
   a_level_top: assert property (@(posedge REF_CLK) disable iff (!NRST)
      TRAP_ACTIVE |-> CPU_INTERRUPT_LEVEL == 4'hF)
      else $error("level not forced during trap");
   a_no_preempt: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (cur_pri == PRI_A && !TRAP_DONE && !HW_RESET_REQ && !SW_RESET_REQ && !WDT_RESET_REQ)
      |=> !TRAP_TAKE)
      else $error("trap preempted by lower request");
   a_trap_flag: assert property (@(posedge REF_CLK) disable iff (!NRST)
      STK_OVER_REQ |=> trap_flag_register[14])
      else $error("trap flag not set");
   a_soft_range: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (TRAP_TAKE && !TRAP_ACTIVE) |-> (TRAP_VECTOR.location[1:0] == 2'b00))
      else $error("soft trap vector misaligned");
   a_vec3_route: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (sel[3][7] == 1'b0 && sel[3][15] == 1'b0))
      else $error("vector 3 took a routed-out source");
endmodule

/* File: sim/xbus_far_model.sv */
`timescale 1ns/1ps
// Peripherals pulse events one cycle late; the CPU ends each trap service after a delay.
module xbus_far_model
(
   input  wire logic        clk,
   input  wire logic [13:0] ev_cmd,
   input  wire logic        trap_active,
   input  wire logic [3:0]  done_delay,
   input  wire logic [3:0]  level_cmd,
   output logic      [13:0] ev,
   output logic             trap_done,
   output logic      [3:0]  cpu_level
);
   logic [3:0] cnt;
   initial
   begin
      ev = 14'h0000;
      trap_done = 1'b0;
      cpu_level = 4'h0;
      cnt = 4'h0;
   end
   always @(posedge clk)
   begin
      ev <= ev_cmd;
      cpu_level <= level_cmd;
      trap_done <= trap_active && !trap_done && cnt == done_delay;
      if (!trap_active || trap_done || cnt == done_delay)
         cnt <= 4'h0;
      else
         cnt <= cnt + 4'h1;
   end
endmodule

/* File: sim/xbus_irq_mux_test.sv */
`timescale 1ns/1ps
module xbus_irq_mux_test
   import xbus_irq_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [13:0] ev_cmd = 14'h0000;
   logic [5:0]  tr = 6'h00;
   logic [5:0]  cb = 6'h00;
   logic        swt = 1'b0;
   logic [6:0]  swn = 7'h00;
   logic [3:0]  dly = 4'h2;
   logic [3:0]  lvl = 4'h5;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, ttake, tact, tdone, got;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rdat;
   logic [3:0]  svec, clvl, cpul;
   logic [13:0] ev;
   trap_vec_t   tvec;
   int          errors = 0;
   int          total_checks = 0;
   logic [31:0] map [14] = '{32'h01000001, 32'h02000200, 32'h00040404, 32'h00080808,
      32'h04000000, 32'h00101010, 32'h00202020, 32'h08000000, 32'h00404040,
      32'h00808080, 32'h00808080, 32'h10000000, 32'h20000000, 32'h40020000};
   logic [31:0] en_mask = 32'h7FFEFEFD;

   always #50 clk = ~clk;

   xbus_far_model far (.clk(clk), .ev_cmd(ev_cmd), .trap_active(tact), .done_delay(dly),
      .level_cmd(lvl), .ev(ev), .trap_done(tdone), .cpu_level(cpul));

   xbus_irq_mux dut (.REF_CLK(clk), .NRST(nrst), .CAN1_EV(ev[0]), .CAN2_EV(ev[1]),
      .I2C_RX_EV(ev[2]), .I2C_TX_EV(ev[3]), .I2C_ERR_EV(ev[4]), .SSC2_RX_EV(ev[5]),
      .SSC2_TX_EV(ev[6]), .SSC2_ERR_EV(ev[7]), .ASC2_RX_EV(ev[8]), .ASC2_TX_EV(ev[9]),
      .ASC2_TXBUF_EV(ev[10]), .ASC2_ERR_EV(ev[11]), .CLOCK_FAULT_EV(ev[12]),
      .PWM2_EV(ev[13]), .HW_RESET_REQ(tr[0]), .SW_RESET_REQ(tr[1]), .WDT_RESET_REQ(tr[2]),
      .NMI_REQ(tr[3]), .STK_OVER_REQ(tr[4]), .STK_UNDER_REQ(tr[5]), .CLASS_B_REQ(cb),
      .SW_TRAP_REQ(swt), .SW_TRAP_NUM(swn), .TRAP_DONE(tdone), .CPU_LEVEL_IN(cpul),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .SHARED_VECTOR(svec), .TRAP_TAKE(ttake),
      .TRAP_VECTOR(tvec), .CPU_INTERRUPT_LEVEL(clvl), .TRAP_ACTIVE(tact));

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic done;
      done = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            done = 1'b1;
            resp = bresp;
            bready <= 1'b0;
         end
      end
      chk("write answer", {31'h0, done}, 32'h1);
      @(posedge clk);
   endtask

   task rd(input logic [31:0] a);
      logic done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            done = 1'b1;
            rdat = rdata;
            resp = rresp;
            rready <= 1'b0;
         end
      end
      chk("read answer", {31'h0, done}, 32'h1);
      @(posedge clk);
   endtask

   task fire(input logic [13:0] m);
      ev_cmd <= m;
      @(posedge clk);
      ev_cmd <= 14'h0000;
      repeat (4) @(posedge clk);
   endtask

   task wt(input int lim);
      got = 1'b0;
      for (int n = 0; n < lim && !got; n++)
      begin
         @(negedge clk);
         got = ttake;
      end
      chk("trap taken", {31'h0, got}, 32'h1);
   endtask

   task take(input logic [5:0] t, input logic [5:0] b, input logic s,
      input logic [15:0] v, input logic [3:0] l);
      tr <= t;
      cb <= b;
      swt <= s;
      @(posedge clk);
      tr <= 6'h00;
      cb <= 6'h00;
      swt <= 1'b0;
      wt(20);
      chk("trap vector", {16'h0, tvec}, {16'h0, v});
      chk("cpu level", {28'h0, clvl}, {28'h0, l});
      chk("trap active", {31'h0, tact}, {31'h0, !s});
      for (int n = 0; n < 40 && tact === 1'b1; n++)
         @(negedge clk);
      @(posedge clk);
   endtask

   task idle_regs;
      for (int g = 0; g < 5; g++)
      begin
         rd(32'(4 * g));
         chk("reset value", rdat, 32'h0);
      end
      rd(32'h00000018);
      chk("unmapped read resp", {30'h0, resp}, 32'h3);
      chk("unmapped read data", rdat, 32'h0);
      wr(32'h0000001C, 32'hFFFFFFFF, 4'hF);
      chk("unmapped write resp", {30'h0, resp}, 32'h3);
      rd(32'h00000014);
      chk("idle status", rdat, {24'h0, 4'h0, lvl});
      chk("idle vectors", {28'h0, svec}, 32'h0);
   endtask

   task routing;
      logic [31:0] m;
      for (int g = 0; g < 4; g++)
      begin
         wr(32'(4 * g), 32'h0000FF00, 4'b0010);
         rd(32'(4 * g));
         chk("enable byte", rdat, {16'h0, en_mask[8 * g +: 8], 8'h00});
      end
      for (int i = 0; i < 14; i++)
      begin
         m = map[i];
         fire(14'(1) << i);
         for (int g = 0; g < 4; g++)
         begin
            rd(32'(4 * g));
            chk("flag byte", rdat, {16'h0, en_mask[8 * g +: 8], m[8 * g +: 8]});
         end
         chk("vector", {28'h0, svec}, {28'h0, |m[31:24], |m[23:16], |m[15:8], |m[7:0]});
         for (int g = 0; g < 4; g++)
            wr(32'(4 * g), 32'h000000FF, 4'b0001);
         @(posedge clk);
         chk("cleared vector", {28'h0, svec}, 32'h0);
      end
   endtask

   task masked;
      wr(32'h00000000, 32'h00000000, 4'b0010);
      fire(14'h0001);
      repeat (3) @(posedge clk);
      rd(32'h00000000);
      chk("masked flag", rdat, 32'h00000001);
      chk("masked vector", {28'h0, svec}, 32'h8);
      wr(32'h00000000, 32'h000000FF, 4'b0001);
      wr(32'h0000000C, 32'h000000FF, 4'b0001);
   endtask

   task traps;
      for (int i = 0; i < 3; i++)
         take(6'h08 << i, 6'h00, 1'b0, {9'(8 * i + 8), 7'(2 * i + 2)}, 4'hF);
      for (int i = 0; i < 6; i++)
         take(6'h00, 6'h01 << i, 1'b0, {9'h028, 7'h0A}, 4'hF);
      rd(32'h00000010);
      chk("trap flags", rdat, 32'h0000E0CF);
      wr(32'h00000010, 32'h0000FFFF, 4'b0011);
      rd(32'h00000010);
      chk("trap flags cleared", rdat, 32'h0);
      swn <= 7'h7F;
      take(6'h00, 6'h00, 1'b1, {9'h1FC, 7'h7F}, 4'h5);
      swn <= 7'h00;
      take(6'h00, 6'h00, 1'b1, {9'h000, 7'h00}, 4'h5);
      for (int i = 0; i < 3; i++)
         take(6'h01 << i, 6'h00, 1'b0, {9'h000, 7'h00}, 4'hF);
   endtask

   task preempt;
      dly <= 4'hC;
      tr <= 6'h08;
      @(posedge clk);
      tr <= 6'h00;
      cb <= 6'h20;
      wt(4);
      chk("first vector", {16'h0, tvec}, {16'h0, 9'h008, 7'h02});
      repeat (6)
      begin
         @(negedge clk);
         chk("held back", {31'h0, ttake}, 32'h0);
      end
      wt(30);
      chk("later vector", {16'h0, tvec}, {16'h0, 9'h028, 7'h0A});
      @(posedge clk);
      cb <= 6'h00;
      tr <= 6'h08;
      @(posedge clk);
      tr <= 6'h00;
      wt(6);
      chk("preempt vector", {16'h0, tvec}, {16'h0, 9'h008, 7'h02});
      dly <= 4'h2;
      for (int n = 0; n < 60 && tact === 1'b1; n++)
         @(negedge clk);
   endtask

   task conclude;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      idle_regs();
      routing();
      masked();
      traps();
      preempt();
      conclude();
   end
endmodule
